// [aec_cfg_pkg.sv]
// Package: register map, field layout and reset values of the event counter configuration block
package aec_cfg_pkg;

    // Register word addresses (one 32-bit word each)
    localparam logic [3:0] ADDR_PWM_DATA    = 4'h0;
    localparam logic [3:0] ADDR_EDGE_SEL    = 4'h1;
    localparam logic [3:0] ADDR_CLK_CTRL    = 4'h2;
    localparam logic [3:0] ADDR_PWM_PERIOD  = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK    = 4'h5;
    localparam logic [3:0] ADDR_COUNT       = 4'h6;

    // Reset values
    localparam logic [15:0] PWM_DATA_RST    = 16'h0000;
    localparam logic [15:0] PWM_PERIOD_RST  = 16'hffff;
    localparam logic [7:0]  EDGE_SEL_RST    = 8'h00;
    localparam logic [7:0]  CLK_CTRL_RST    = 8'h00;
    localparam logic [2:0]  IRQ_RST         = 3'h0;

    // Field positions
    localparam int HI_EDGE_POS    = 6;
    localparam int LO_EDGE_POS    = 4;
    localparam int GATE_EDGE_POS  = 2;
    localparam int PWM_EN_POS     = 1;
    localparam int HI_CLK_POS     = 6;
    localparam int LO_CLK_POS     = 4;
    localparam int PWM_CLK_POS    = 1;

    // Interrupt status bits
    localparam int IRQ_GATE_BIT   = 0;
    localparam int IRQ_HI_OVF_BIT = 1;
    localparam int IRQ_LO_OVF_BIT = 2;

    // Edge sensing codes
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    // Counter clock codes
    localparam logic [1:0] CLK_PIN   = 2'h0;
    localparam logic [1:0] CLK_DIV2  = 2'h1;
    localparam logic [1:0] CLK_DIV4  = 2'h2;
    localparam logic [1:0] CLK_DIV8  = 2'h3;

    // Avalon answer for unmapped and write-only reads
    localparam logic [31:0] READ_FILL = 32'h0000_0000;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_DONE = 2'b01
    } bus_state_e;

endpackage

// [async_event_counter_config.sv]
// Event counter configuration: registers, edge select, clock select, PWM gate and interrupts
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps

module async_event_counter_config
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        high_event_pin,
    input  wire logic        low_event_pin,
    input  wire logic        gate_interrupt_pin,
    output logic             gate_pwm_output,
    output logic             high_count_tick,
    output logic             low_count_tick,
    output logic             irq
);
    import aec_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        bus_state_e  bus;
        logic [31:0] rdata;
        logic [15:0] pwm_data;
        logic [15:0] pwm_period;
        logic [7:0]  edge_sel;
        logic [7:0]  clk_ctrl;
        logic [2:0]  irq_status;
        logic [2:0]  irq_mask;
        logic [3:0]  div;
        logic [15:0] pwm_cnt;
        logic        pwm_out;
        logic        hi_tick;
        logic        lo_tick;
        logic [7:0]  hi_count;
        logic [7:0]  lo_count;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic        hi_edge;
    logic        lo_edge;
    logic        gate_edge;
    logic        gate_level;
    logic [1:0]  gate_mode;

    ////////////////////////////////////////////////////////////////////////////
    // Edge detectors

    edge_sense u_hi_edge (
        .clk_sys (clk_sys),
        .rst     (rst),
        .level   (high_event_pin),
        .mode    (s_q.edge_sel[HI_EDGE_POS +: 2]),
        .pulse   (hi_edge)
    );

    edge_sense u_lo_edge (
        .clk_sys (clk_sys),
        .rst     (rst),
        .level   (low_event_pin),
        .mode    (s_q.edge_sel[LO_EDGE_POS +: 2]),
        .pulse   (lo_edge)
    );

    edge_sense u_gate_edge (
        .clk_sys (clk_sys),
        .rst     (rst),
        .level   (gate_level),
        .mode    (gate_mode),
        .pulse   (gate_edge)
    );

    assign gate_level = s_q.edge_sel[PWM_EN_POS] ? s_q.pwm_out : gate_interrupt_pin;
    assign gate_mode  = s_q.edge_sel[GATE_EDGE_POS +: 2];

    ////////////////////////////////////////////////////////////////////////////
    // Divider helpers

    function automatic logic div_tick(input logic [1:0] sel, input logic [3:0] div, input logic pin_edge);
        case (sel)
            CLK_PIN:  div_tick = pin_edge;
            CLK_DIV2: div_tick = div[0];
            CLK_DIV4: div_tick = &div[1:0];
            CLK_DIV8: div_tick = &div[2:0];
            default:  div_tick = 1'b0;
        endcase
    endfunction

    function automatic logic pwm_tick(input logic [2:0] sel, input logic [3:0] div);
        case (sel)
            3'h0:    pwm_tick = div[0];
            3'h1:    pwm_tick = &div[1:0];
            3'h2:    pwm_tick = &div[2:0];
            3'h3:    pwm_tick = &div[3:0];
            default: pwm_tick = div[0];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        logic        acc;
        logic        wr;
        logic        hi_in;
        logic        lo_in;
        logic [2:0]  clr;
        logic [2:0]  ev;
        acc   = (avs_read | avs_write) && (s_q.bus == BUS_IDLE);
        // Write lands at the edge where waitrequest is low
        wr    = avs_write && (s_q.bus == BUS_DONE);
        clr   = 3'h0;
        ev    = 3'h0;
        hi_in = 1'b0;
        lo_in = 1'b0;
        s_d   = s_q;

        s_d.div = s_q.div + 4'h1;

        if (!s_q.edge_sel[PWM_EN_POS])
        begin
            s_d.pwm_cnt = 16'h0000;
            s_d.pwm_out = 1'b0;
        end
        else if (pwm_tick(s_q.clk_ctrl[PWM_CLK_POS +: 3], s_q.div))
        begin
            s_d.pwm_cnt = (s_q.pwm_cnt >= s_q.pwm_period) ? 16'h0000 : s_q.pwm_cnt + 16'h0001;
            s_d.pwm_out = (s_d.pwm_cnt < s_q.pwm_data);
        end

        hi_in = div_tick(s_q.clk_ctrl[HI_CLK_POS +: 2], s_q.div, hi_edge);
        lo_in = div_tick(s_q.clk_ctrl[LO_CLK_POS +: 2], s_q.div, lo_edge);

        s_d.hi_tick = hi_in & gate_level;
        s_d.lo_tick = lo_in & gate_level;
        if (s_d.hi_tick)
        begin
            s_d.hi_count = s_q.hi_count + 8'h01;
        end
        if (s_d.lo_tick)
        begin
            s_d.lo_count = s_q.lo_count + 8'h01;
        end

        ev[IRQ_GATE_BIT]   = gate_edge;
        ev[IRQ_HI_OVF_BIT] = s_d.hi_tick && (s_q.hi_count == 8'hff);
        ev[IRQ_LO_OVF_BIT] = s_d.lo_tick && (s_q.lo_count == 8'hff);

        // Bus handshake: one wait cycle, answer in the second
        s_d.bus = acc ? BUS_DONE : BUS_IDLE;
        if (acc && avs_read)
        begin
            case (avs_address)
                ADDR_PWM_DATA:   s_d.rdata = READ_FILL;
                ADDR_EDGE_SEL:   s_d.rdata = {24'h0, s_q.edge_sel};
                ADDR_CLK_CTRL:   s_d.rdata = {24'h0, s_q.clk_ctrl};
                ADDR_PWM_PERIOD: s_d.rdata = {16'h0, s_q.pwm_period};
                ADDR_IRQ_STATUS: s_d.rdata = {29'h0, s_q.irq_status};
                ADDR_IRQ_MASK:   s_d.rdata = {29'h0, s_q.irq_mask};
                ADDR_COUNT:      s_d.rdata = {16'h0, s_q.hi_count, s_q.lo_count};
                default:         s_d.rdata = READ_FILL;
            endcase
        end

        if (wr)
        begin
            case (avs_address)
                ADDR_PWM_DATA:
                begin
                    if (&avs_byteenable[1:0])
                    begin
                        s_d.pwm_data = avs_writedata[15:0];
                    end
                end
                ADDR_PWM_PERIOD:
                begin
                    if (&avs_byteenable[1:0])
                    begin
                        s_d.pwm_period = avs_writedata[15:0];
                    end
                end
                ADDR_EDGE_SEL:
                begin
                    if (avs_byteenable[0])
                    begin
                        s_d.edge_sel = avs_writedata[7:0];
                    end
                end
                ADDR_CLK_CTRL:
                begin
                    if (avs_byteenable[0])
                    begin
                        s_d.clk_ctrl = avs_writedata[7:0];
                    end
                end
                ADDR_IRQ_STATUS:
                begin
                    if (avs_byteenable[0])
                    begin
                        clr = avs_writedata[2:0];
                    end
                end
                ADDR_IRQ_MASK:
                begin
                    if (avs_byteenable[0])
                    begin
                        s_d.irq_mask = avs_writedata[2:0];
                    end
                end
                default:
                begin
                    s_d.irq_mask = s_q.irq_mask;
                end
            endcase
        end

        // Set wins over clear
        s_d.irq_status = (s_q.irq_status & ~clr) | ev;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s_q            <= '0;
            s_q.bus        <= BUS_IDLE;
            s_q.pwm_data   <= PWM_DATA_RST;
            s_q.pwm_period <= PWM_PERIOD_RST;
            s_q.edge_sel   <= EDGE_SEL_RST;
            s_q.clk_ctrl   <= CLK_CTRL_RST;
            s_q.irq_status <= IRQ_RST;
            s_q.irq_mask   <= IRQ_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign avs_waitrequest = (avs_read | avs_write) && (s_q.bus == BUS_IDLE);
    assign avs_readdata    = s_q.rdata;
    assign gate_pwm_output = s_q.pwm_out;
    assign high_count_tick = s_q.hi_tick;
    assign low_count_tick  = s_q.lo_tick;
    assign irq             = |(s_q.irq_status & s_q.irq_mask);

endmodule

// [async_event_counter_config_assertions.sv]
// Port checker for the event counter configuration block
`timescale 1ns/100ps
module async_event_counter_config_assertions
    import aec_cfg_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        high_event_pin,
    input wire logic        low_event_pin,
    input wire logic        gate_interrupt_pin,
    input wire logic        gate_pwm_output,
    input wire logic        high_count_tick,
    input wire logic        low_count_tick,
    input wire logic        irq
);
    logic [7:0] edge_q;
    logic [7:0] clk_q;
    logic [2:0] mask_q;
    logic       wr_ok;
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    ////////////////////////////////////////////////////////////////
    // Shadow of the byte registers
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            edge_q <= EDGE_SEL_RST;
            clk_q <= CLK_CTRL_RST;
            mask_q <= IRQ_RST;
        end
        else
        begin
            if (wr_ok && avs_address == ADDR_EDGE_SEL)
                edge_q <= avs_writedata[7:0];
            if (wr_ok && avs_address == ADDR_CLK_CTRL)
                clk_q <= avs_writedata[7:0];
            if (wr_ok && avs_address == ADDR_IRQ_MASK)
                mask_q <= avs_writedata[2:0];
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("access not answered in its second cycle");
    a_edge_read: assert property (avs_read && !avs_waitrequest && avs_address == ADDR_EDGE_SEL
        |-> avs_readdata == {24'h0, edge_q}) else $error("edge select read back wrong");
    a_clk_read: assert property (avs_read && !avs_waitrequest && avs_address == ADDR_CLK_CTRL
        |-> avs_readdata == {24'h0, clk_q}) else $error("clock control read back wrong");
    a_fill_read: assert property (avs_read && !avs_waitrequest && avs_address == ADDR_PWM_DATA
        |-> avs_readdata == READ_FILL) else $error("pwm data read not filler");
    a_gate_low: assert property ((!edge_q[PWM_EN_POS] && !gate_interrupt_pin) [*3]
        |-> !high_count_tick && !low_count_tick) else $error("tick while gate low");
    a_pwm_off: assert property ((!edge_q[PWM_EN_POS]) [*3] |-> !gate_pwm_output)
        else $error("pwm output while halted");
    a_irq_mask: assert property ((mask_q == 3'h0) [*2] |-> !irq)
        else $error("irq with all masked");
    a_hi_div4: assert property ((clk_q[7:6] == CLK_DIV4) [*4] ##0 high_count_tick
        |=> (!high_count_tick) [*3]) else $error("high ticks closer than four");
    a_lo_div8: assert property ((clk_q[5:4] == CLK_DIV8) [*8] ##0 low_count_tick
        |=> (!low_count_tick) [*7]) else $error("low ticks closer than eight");
    c_irq: cover property ($rose(irq));
    c_pwm: cover property ($rose(gate_pwm_output));
    c_tick: cover property (high_count_tick && low_count_tick);
    c_pins: cover property (high_event_pin && low_event_pin);
endmodule
bind async_event_counter_config async_event_counter_config_assertions u_async_event_counter_config_assertions
(
    .clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .high_event_pin, .low_event_pin, .gate_interrupt_pin, .gate_pwm_output,
    .high_count_tick, .low_count_tick, .irq
);

// [async_event_counter_config_bench.sv]
// Self-checking bench for the event counter configuration block
`timescale 1ns/100ps
module async_event_counter_config_bench;
    import aec_cfg_pkg::*;
    typedef struct packed {logic [3:0] a; logic [31:0] d; logic [3:0] be; logic [31:0] e;} row_s;
    logic        clk_sys, rst, avs_read, avs_write, avs_waitrequest, irq, gate_pwm_output;
    logic        high_event_pin, low_event_pin, gate_interrupt_pin, high_count_tick, low_count_tick;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [7:0]  dh, dl;
    int          n_mismatch = 0, check_count = 0, cycles = 0, hi_cnt;
    row_s        rows [12] = '{'{ADDR_EDGE_SEL, 32'h40, 4'h1, 32'h40}, '{ADDR_EDGE_SEL, 32'h90, 4'h1, 32'h90},
        '{ADDR_EDGE_SEL, 32'h28, 4'h1, 32'h28}, '{ADDR_EDGE_SEL, 32'h04, 4'he, 32'h28},
        '{ADDR_CLK_CTRL, 32'hc0, 4'h1, 32'hc0}, '{ADDR_CLK_CTRL, 32'h70, 4'h1, 32'h70},
        '{ADDR_CLK_CTRL, 32'ha6, 4'h1, 32'ha6}, '{ADDR_CLK_CTRL, 32'h04, 4'h1, 32'h04},
        '{ADDR_PWM_PERIOD, 32'h07, 4'h3, 32'h07}, '{ADDR_PWM_PERIOD, 32'haa, 4'h1, 32'h07},
        '{ADDR_PWM_DATA, 32'h04, 4'h3, READ_FILL}, '{4'hf, 32'h01, 4'hf, 32'h00}};
    async_event_counter_config u_async_event_counter_config
    (
        .clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .high_event_pin, .low_event_pin, .gate_interrupt_pin, .gate_pwm_output,
        .high_count_tick, .low_count_tick, .irq
    );
    event_source u_event_source (.clk_sys, .high_event_pin, .low_event_pin, .gate_interrupt_pin);
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, 4'hf);
    endtask
    task automatic window(input int n, input int p);
        logic [31:0] c0;
        bus(ADDR_COUNT, 1'b0, 32'h0, 4'hf);
        c0 = q;
        u_event_source.pulses(p);
        repeat (n) @(posedge clk_sys);
        bus(ADDR_COUNT, 1'b0, 32'h0, 4'hf);
        dh = q[15:8] - c0[15:8];
        dl = q[7:0] - c0[7:0];
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        {rst, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = {3'b100, 40'h0};
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        bus(ADDR_EDGE_SEL, 1'b0, 32'h0, 4'hf);
        check(q, {24'h0, EDGE_SEL_RST});
        bus(ADDR_CLK_CTRL, 1'b0, 32'h0, 4'hf);
        check(q, {24'h0, CLK_CTRL_RST});
        bus(ADDR_PWM_PERIOD, 1'b0, 32'h0, 4'hf);
        check(q, {16'h0, PWM_PERIOD_RST});
        check({30'h0, irq, gate_pwm_output}, 32'h0);
        foreach (rows[i])
        begin
            bus(rows[i].a, 1'b1, rows[i].d, rows[i].be);
            bus(rows[i].a, 1'b0, 32'h0, 4'hf);
            check(q, rows[i].e);
        end
        wr(ADDR_IRQ_MASK, 32'h1);
        for (int c = 0; c < 3; c++)
        begin
            wr(ADDR_EDGE_SEL, 32'(c) << GATE_EDGE_POS);
            wr(ADDR_IRQ_STATUS, 32'h7);
            u_event_source.gate(1'b1);
            bus(ADDR_IRQ_STATUS, 1'b0, 32'h0, 4'hf);
            check(32'(q[0]), 32'(c != 0));
            wr(ADDR_IRQ_STATUS, 32'h7);
            u_event_source.gate(1'b0);
            check(32'(irq), 32'(c != 1));
            wr(ADDR_IRQ_STATUS, 32'h7);
        end
        wr(ADDR_IRQ_MASK, 32'h0);
        u_event_source.gate(1'b1);
        check(32'(irq), 32'h0);
        wr(ADDR_IRQ_MASK, 32'h1);
        check(32'(irq), 32'h1);
        wr(ADDR_IRQ_STATUS, 32'h1);
        check(32'(irq), 32'h0);
        wr(ADDR_CLK_CTRL, 32'hb0);
        window(64, 0);
        check(32'(dh >= 15 && dh <= 18 && dl >= 7 && dl <= 10), 32'h1);
        u_event_source.gate(1'b0);
        window(64, 0);
        check({dh, dl}, 32'h0);
        wr(ADDR_CLK_CTRL, 32'h00);
        u_event_source.gate(1'b1);
        for (int c = 0; c < 3; c++)
        begin
            wr(ADDR_EDGE_SEL, 32'(c) * 32'h50);
            window(6, 3);
            check({dh, dl}, (c == 2) ? 32'h0606 : 32'h0303);
        end
        u_event_source.gate(1'b0);
        wr(ADDR_CLK_CTRL, 32'h40);
        wr(ADDR_EDGE_SEL, 32'h02);
        hi_cnt = 0;
        repeat (128)
        begin
            @(posedge clk_sys);
            hi_cnt += (gate_pwm_output === 1'b1) ? 1 : 0;
        end
        check(32'(hi_cnt >= 50 && hi_cnt <= 70), 32'h1);
        window(32, 0);
        check(32'(dh != 0), 32'h1);
        wr(ADDR_EDGE_SEL, 32'h00);
        repeat (3) @(posedge clk_sys);
        check(32'(gate_pwm_output), 32'h0);
        wr(ADDR_PWM_DATA, 32'h08);
        conclude();
    end
endmodule

// [edge_sense.sv]
// Edge detector with selectable falling, rising or both edge sensing
`timescale 1ns/100ps
module edge_sense
    import aec_cfg_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       level,
    input  wire logic [1:0] mode,
    output logic            pulse
);
    import aec_cfg_pkg::*;

    typedef struct packed {
        logic prev;
    } state_s;

    state_s s_q;
    state_s s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.prev = level;
        case (mode)
            EDGE_FALL: pulse = s_q.prev & ~level;
            EDGE_RISE: pulse = ~s_q.prev & level;
            EDGE_BOTH: pulse = s_q.prev ^ level;
            default:   pulse = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule

// [event_source.sv]
// Model of the external event sources and gate input
`timescale 1ns/100ps
module event_source
(
    input  wire logic clk_sys,
    output logic      high_event_pin,
    output logic      low_event_pin,
    output logic      gate_interrupt_pin
);
    initial
    begin
        high_event_pin = 1'b0;
        low_event_pin = 1'b0;
        gate_interrupt_pin = 1'b0;
    end
    // Full pulses on both event pins, three cycles per level
    task automatic pulses(input int n);
        repeat (n)
        begin
            repeat (3) @(posedge clk_sys);
            high_event_pin <= 1'b1;
            low_event_pin <= 1'b1;
            repeat (3) @(posedge clk_sys);
            high_event_pin <= 1'b0;
            low_event_pin <= 1'b0;
        end
    endtask
    task automatic gate(input logic v);
        @(posedge clk_sys);
        gate_interrupt_pin <= v;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule
